// File: hdl/rdsg_consts.vh
// Constants for the ROM and debug security gate.
`ifndef RDSG_CONSTS_VH
`define RDSG_CONSTS_VH
// ==========================================================================
// Address map
`define RDSG_ROM_BASE 32'hbfc0_0000
`define RDSG_ROM_AREA_BITS 19
`define RDSG_AREA_COUNT 4
`define RDSG_ROM_SIZE 32'h0020_0000
`define RDSG_DENY_READ_DATA 32'h0000_0098
// ==========================================================================
// Master codes
`define RDSG_MST_CPU 3'h0
`define RDSG_MST_DMA 3'h1
`define RDSG_MST_DBG 3'h2
`define RDSG_MST_BOOT 3'h3
`define RDSG_MST_WRITER 3'h4
`define RDSG_MST_PROBE 3'h5
// ==========================================================================
// Flash command codes
`define RDSG_CMD_NONE 3'h0
`define RDSG_CMD_WRITE 3'h1
`define RDSG_CMD_ERASE 3'h2
`define RDSG_CMD_PROT_CLR 3'h3
`define RDSG_CMD_SEC_CLR 3'h4
`define RDSG_CMD_OTHER 3'h5
// ==========================================================================
// Reset values
`define RDSG_GUARD_RESET 1'h0
`define RDSG_PROTECT_RESET 4'h0
`endif

// File: hdl/rdsg_rom_decode.v
// Address classifier: ROM membership and 512 kB area index.
`timescale 1ns/10ps
`include "rdsg_consts.vh"

module rdsg_rom_decode (
  // Address in
  input wire [31:0] i_addr,
  // Classification out
  output wire o_in_rom,
  output wire [1:0] o_area
);

  wire [31:0] offset;

  assign offset = i_addr - `RDSG_ROM_BASE;
  assign o_in_rom = (i_addr >= `RDSG_ROM_BASE) && (offset < `RDSG_ROM_SIZE);
  assign o_area = offset[`RDSG_ROM_AREA_BITS+1:`RDSG_ROM_AREA_BITS];

endmodule

// File: hdl/rdsg_gate.v
// ROM, flash and debug-probe security gate between bus masters and flash.
`timescale 1ns/10ps
`include "rdsg_consts.vh"

// Function
// - Refuse write and erase to protected areas.
// - Secured flash denies reads from outside flash.
// - Secured flash ignores ordinary flash commands.
// - ROM and probe security need flash security.
// - Protection erase when secured wipes flash.
// - Block ROM data access from outside ROM.
// - Block DMA transfers out of ROM.
// - Block debug port ROM data access.
// - Block boot and writer ROM data access.
// - Guard registers refuse outside-ROM instructions.
// - Limit command sequences per mode.
// - Allow ROM loads from ROM instructions.
// - Allow loads outside ROM from anywhere.
// - Allow branches into ROM from anywhere.
// - Keep trace and breakpoints for debug.
// - Correction-substituted code counts as outside ROM.
// - Probe security blocks debug probe reads.
// - Outside-ROM DMA config write raises bus error.
module rdsg_gate (
  // Clock and reset
  input wire i_clock,
  input wire i_sys_rst,
  // Mode
  input wire i_writer_mode,
  // Access request from a bus master
  input wire i_req,
  input wire [2:0] i_master,
  input wire i_write,
  input wire i_fetch,
  input wire [31:0] i_addr,
  input wire [31:0] i_pc,
  input wire i_pc_substituted,
  input wire [31:0] i_wdata,
  // Flash command request
  input wire i_cmd_req,
  input wire [2:0] i_cmd,
  // Guard register writes
  input wire i_guard_one_wr,
  input wire i_guard_two_wr,
  input wire i_guard_wdata,
  // DMA configuration register write
  input wire i_dma_cfg_wr,
  // Flash side
  input wire [3:0] i_area_protect_bits,
  input wire [31:0] i_flash_rdata,
  input wire i_flash_ready,
  // Debug trace and breakpoint request
  input wire i_trace_req,
  // Flash access out
  output wire o_flash_req,
  output wire o_flash_write,
  output wire [31:0] o_flash_addr,
  output wire [31:0] o_flash_wdata,
  // Flash command out
  output wire o_cmd_req,
  output wire [2:0] o_cmd,
  output reg o_chip_wipe,
  // Answers
  output wire o_ack,
  output reg [31:0] o_rdata,
  output reg o_denied,
  output reg o_bus_error,
  output wire o_dma_cfg_wr,
  output wire o_trace_ok,
  // Status
  output wire o_flash_secure,
  output wire o_rom_secure,
  output wire o_probe_secure,
  output wire o_rom_guard_reg_one,
  output wire o_rom_guard_reg_two
);

  // ==========================================================================
  // Input synchroniser for the pin-borne writer mode signal
  reg writer_meta;
  reg writer_mode;

  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      writer_meta <= 1'h0;
      writer_mode <= 1'h0;
    end else begin
      writer_meta <= i_writer_mode;
      writer_mode <= writer_meta;
    end
  end

  // ==========================================================================
  // Address classification
  wire addr_in_rom;
  wire [1:0] addr_area;
  wire pc_raw_in_rom;

  rdsg_rom_decode u_addr_dec (
    .i_addr(i_addr),
    .o_in_rom(addr_in_rom),
    .o_area(addr_area)
  );

  rdsg_rom_decode u_pc_dec (
    .i_addr(i_pc),
    .o_in_rom(pc_raw_in_rom),
    .o_area()
  );

  // Only membership matters for the PC, so its area index is left open.

  // Substituted code is outside.
  // The PC points into ROM but the opcode came from RAM, so it gets no trust.
  wire pc_in_rom;
  assign pc_in_rom = pc_raw_in_rom && !i_pc_substituted && (i_master == `RDSG_MST_CPU);

  // ==========================================================================
  // Security state
  reg rom_guard_reg_one;
  reg rom_guard_reg_two;
  wire flash_secure;
  wire rom_secure;
  wire probe_secure;

  assign flash_secure = &i_area_protect_bits;
  assign rom_secure = flash_secure && rom_guard_reg_one;
  assign probe_secure = flash_secure && rom_guard_reg_two;

  // ==========================================================================
  // Access decision
  reg allow;

  always @* begin
    allow = 1'b1;
    if (addr_in_rom && !i_fetch) begin
      if (i_write && i_area_protect_bits[addr_area]) begin
        allow = 1'b0;
      end
      if (flash_secure && !pc_in_rom) begin
        allow = 1'b0;
      end
      if (rom_secure) begin
        if (!pc_in_rom) begin
          allow = 1'b0;
        end
        if (i_master == `RDSG_MST_DMA) begin
          allow = 1'b0;
        end
        if (i_master == `RDSG_MST_DBG) begin
          allow = 1'b0;
        end
        if ((i_master == `RDSG_MST_BOOT) || (i_master == `RDSG_MST_WRITER)) begin
          allow = 1'b0;
        end
        if (pc_in_rom && !i_write) begin
          allow = 1'b1;
        end
      end
      if (probe_secure && (i_master == `RDSG_MST_PROBE)) begin
        allow = 1'b0;
      end
    end
    // Non-ROM data always passes; fetches into ROM pass.
    if (!addr_in_rom || i_fetch) begin
      allow = 1'b1;
    end
  end

  assign o_flash_req = i_req && allow;
  assign o_flash_write = i_write;
  assign o_flash_addr = i_addr;
  assign o_flash_wdata = i_wdata;
  assign o_ack = (i_req && !allow) || (o_flash_req && i_flash_ready);

  // Denied reads return a fixed pattern.
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rdata <= 32'h0000_0000;
      o_denied <= 1'h0;
    end else begin
      o_denied <= i_req && !allow;
      if (i_req && !allow) begin
        o_rdata <= `RDSG_DENY_READ_DATA;
      end else if (o_flash_req && i_flash_ready) begin
        o_rdata <= i_flash_rdata;
      end
    end
  end

  // ==========================================================================
  // Guard registers
  wire guard_ok;
  assign guard_ok = !rom_secure || pc_in_rom;

  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rom_guard_reg_one <= `RDSG_GUARD_RESET;
      rom_guard_reg_two <= `RDSG_GUARD_RESET;
    end else begin
      if (i_guard_one_wr && guard_ok) begin
        rom_guard_reg_one <= i_guard_wdata;
      end
      if (i_guard_two_wr && (guard_ok && (!probe_secure || pc_in_rom))) begin
        rom_guard_reg_two <= i_guard_wdata;
      end
    end
  end

  // ==========================================================================
  // DMA configuration write filter
  wire dma_cfg_ok;
  assign dma_cfg_ok = !flash_secure || pc_in_rom;
  assign o_dma_cfg_wr = i_dma_cfg_wr && dma_cfg_ok;

  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_bus_error <= 1'h0;
    end else begin
      o_bus_error <= i_dma_cfg_wr && !dma_cfg_ok;
    end
  end

  // ==========================================================================
  // Flash command filter
  reg cmd_allow;
  reg next_wipe;
  wire cmd_is_clear;

  assign cmd_is_clear = (i_cmd == `RDSG_CMD_PROT_CLR) || (i_cmd == `RDSG_CMD_SEC_CLR);

  always @* begin
    cmd_allow = 1'b1;
    next_wipe = 1'b0;
    if (flash_secure && !cmd_is_clear) begin
      cmd_allow = 1'b0;
    end
    // Protected areas refuse write and erase.
    if (((i_cmd == `RDSG_CMD_WRITE) || (i_cmd == `RDSG_CMD_ERASE))
        && addr_in_rom && i_area_protect_bits[addr_area]) begin
      cmd_allow = 1'b0;
    end
    if (rom_secure) begin
      if (writer_mode && !cmd_is_clear) begin
        cmd_allow = 1'b0;
      end
      // Single and boot mode refuse any ROM-addressed sequence, wherever the code runs.
      if (!writer_mode && addr_in_rom) begin
        cmd_allow = 1'b0;
      end
    end
    if (flash_secure && cmd_allow && (i_cmd == `RDSG_CMD_PROT_CLR)) begin
      next_wipe = 1'b1;
    end
  end

  assign o_cmd_req = i_cmd_req && cmd_allow;
  assign o_cmd = i_cmd;

  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_chip_wipe <= 1'h0;
    end else begin
      o_chip_wipe <= i_cmd_req && next_wipe;
    end
  end

  // ==========================================================================
  // Debug trace and status
  // Trace and breakpoints stay.
  assign o_trace_ok = i_trace_req;
  assign o_flash_secure = flash_secure;
  assign o_rom_secure = rom_secure;
  assign o_probe_secure = probe_secure;
  assign o_rom_guard_reg_one = rom_guard_reg_one;
  assign o_rom_guard_reg_two = rom_guard_reg_two;

endmodule

// File: tb/rdsg_chk.sv
// Checker of the security gate decisions at its ports.
`timescale 1ns/10ps
`include "rdsg_consts.vh"
module rdsg_chk (
  // Clock, reset and requests
  input wire i_clock, i_sys_rst, i_req, i_write, i_fetch, i_pc_substituted,
  input wire i_cmd_req, i_dma_cfg_wr,
  input wire [2:0] i_master, i_cmd,
  input wire [31:0] i_addr, i_pc,
  input wire [3:0] i_area_protect_bits,
  // Answers
  input wire o_flash_req, o_flash_write, o_cmd_req, o_chip_wipe, o_ack, o_denied,
  input wire o_bus_error, o_dma_cfg_wr, o_flash_secure, o_rom_secure,
  input wire [31:0] o_rdata
);
  // ==========================================
  // Address classes
  wire a_rom = (i_addr - `RDSG_ROM_BASE) < `RDSG_ROM_SIZE;
  wire pc_in = (i_pc - `RDSG_ROM_BASE) < `RDSG_ROM_SIZE;
  wire pc_rom = pc_in && !i_pc_substituted && i_master == `RDSG_MST_CPU;
  wire rd = i_req && !i_write && !i_fetch && a_rom;
  wire prot = i_area_protect_bits[i_addr[20:19]];
  wire refuse = o_ack && !o_flash_req;
  wire bad_cmd = i_cmd == `RDSG_CMD_WRITE || i_cmd == `RDSG_CMD_ERASE
    || i_cmd == `RDSG_CMD_OTHER;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  // ==========================================
  // Properties
  property p_prot; i_req && i_write && !i_fetch && a_rom && prot |-> !o_flash_req; endproperty
  a_prot: assert property (p_prot) else $error("protected write passed");
  property p_outrd;
    o_flash_secure && rd && !pc_rom |-> !o_flash_req ##1
      (o_denied && o_rdata == `RDSG_DENY_READ_DATA);
  endproperty
  a_outrd: assert property (p_outrd) else $error("outside read passed");
  property p_rsec; o_rom_secure && i_req && a_rom && !i_fetch && !pc_rom |-> !o_flash_req;
  endproperty
  a_rsec: assert property (p_rsec) else $error("rom data access passed");
  property p_fetch; i_req && i_fetch && a_rom |-> o_flash_req; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch blocked");
  property p_cmd; o_flash_secure && i_cmd_req && bad_cmd |-> !o_cmd_req; endproperty
  a_cmd: assert property (p_cmd) else $error("command passed");
  property p_wipe;
    o_flash_secure && !o_rom_secure && i_cmd_req && i_cmd == `RDSG_CMD_PROT_CLR |=> o_chip_wipe;
  endproperty
  a_wipe: assert property (p_wipe) else $error("no wipe");
  property p_cfg; o_rom_secure && i_dma_cfg_wr && !pc_rom |-> !o_dma_cfg_wr ##1 o_bus_error;
  endproperty
  a_cfg: assert property (p_cfg) else $error("config write passed");
  property p_deny; o_denied |-> $past(refuse); endproperty
  a_deny: assert property (p_deny) else $error("deny without refusal");
endmodule
bind rdsg_gate rdsg_chk u_chk (.*);

// File: tb/rdsg_flash_model.sv
// Flash array model answering the gated accesses.
`timescale 1ns/10ps
module rdsg_flash_model (
  input wire i_clock, i_sys_rst, i_req, i_write,
  input wire [31:0] i_addr, i_wdata,
  input wire [3:0] i_wait,
  output wire o_ready,
  output wire [31:0] o_rdata
);
  reg [31:0] mem [0:15];
  reg [3:0] cnt;
  integer k;
  wire [31:0] word = mem[i_addr[5:2]];
  assign o_ready = i_req && cnt >= i_wait;
  // An unanswered word shows its inverse, so a stale capture cannot pass.
  assign o_rdata = o_ready ? word : ~word;
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt <= 4'h0;
      for (k = 0; k < 16; k = k + 1)
        mem[k] <= {28'h5a5a_a5a, k[3:0]};
    end else begin
      cnt <= (!i_req || o_ready) ? 4'h0 : cnt + 4'h1;
      if (o_ready && i_write)
        mem[i_addr[5:2]] <= i_wdata;
    end
  end
endmodule

// File: tb/rom_debug_security_gate_tb_top.sv
// Self-checking bench for the security gate.
`timescale 1ns/10ps
`include "rdsg_consts.vh"
module rom_debug_security_gate_tb_top;
  localparam [31:0] RA = 32'hbfc0_0010;
  localparam [31:0] OUT = 32'h8000_0000;
  localparam [31:0] D4 = 32'h5a5a_a5a4;
  reg i_clock, i_sys_rst, i_writer_mode, i_req, i_write, i_fetch, i_pc_substituted;
  reg i_cmd_req, i_guard_one_wr, i_guard_two_wr, i_guard_wdata, i_dma_cfg_wr, i_trace_req;
  reg [2:0] i_master, i_cmd;
  reg [31:0] i_addr, i_pc, i_wdata;
  reg [3:0] i_area_protect_bits, fwait;
  reg seen;
  integer error_cnt, checked, cyc, m;
  wire o_flash_req, o_flash_write, o_cmd_req, o_chip_wipe, o_ack, o_denied, o_bus_error;
  wire o_dma_cfg_wr, o_trace_ok, o_flash_secure, o_rom_secure, o_probe_secure;
  wire o_rom_guard_reg_one, o_rom_guard_reg_two, i_flash_ready;
  wire [31:0] o_flash_addr, o_flash_wdata, o_rdata, i_flash_rdata;
  wire [2:0] o_cmd;
  rdsg_gate dut (.*);
  rdsg_flash_model u_flash (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_req(o_flash_req),
    .i_write(o_flash_write), .i_addr(o_flash_addr), .i_wdata(o_flash_wdata),
    .i_wait(fwait), .o_ready(i_flash_ready), .o_rdata(i_flash_rdata));
  always #20 i_clock = ~i_clock;
  // ==========================================
  // Shared tasks
  task chk(input [31:0] v, input [31:0] e);
    begin
      checked = checked + 1;
      if (v !== e) begin
        error_cnt = error_cnt + 1;
        $display("unexpected at %0t: saw %h, wanted %h", $time, v, e);
      end
    end
  endtask
  task acc(input [2:0] mm, input w, f, input [31:0] a, pc, input s, dn, input [31:0] d);
    integer n;
    begin
      @(posedge i_clock);
      {i_req, i_master, i_write, i_fetch, i_addr, i_pc} <= {1'b1, mm, w, f, a, pc};
      {i_pc_substituted, i_wdata} <= {s, d};
      seen = 1'b0;
      for (n = 0; n < 20 && !seen; n = n + 1) begin
        @(negedge i_clock);
        seen = (o_ack === 1'b1);
        @(posedge i_clock);
      end
      i_req <= 1'b0;
      #1;
      // Every access completes on the bus.
      chk(seen, 1'b1);
      chk(o_denied, dn);
      if (dn)
        chk(o_rdata, `RDSG_DENY_READ_DATA);
      else if (!w)
        chk(o_rdata, d);
    end
  endtask
  task cmd(input [2:0] c, input ok);
    begin
      @(posedge i_clock);
      {i_cmd_req, i_cmd} <= {1'b1, c};
      @(negedge i_clock);
      chk(o_cmd_req, ok);
      @(posedge i_clock);
      i_cmd_req <= 1'b0;
      #1;
    end
  endtask
  task pulse(input [2:0] sel, input v, input [31:0] pc);
    begin
      @(posedge i_clock);
      {i_guard_one_wr, i_guard_two_wr, i_dma_cfg_wr} <= sel;
      {i_guard_wdata, i_pc, i_master, i_pc_substituted} <= {v, pc, `RDSG_MST_CPU, 1'b0};
      @(negedge i_clock);
      seen = o_dma_cfg_wr;
      @(posedge i_clock);
      {i_guard_one_wr, i_guard_two_wr, i_dma_cfg_wr} <= 3'h0;
      #1;
    end
  endtask
  // ==========================================
  // Scenarios
  task t_protect;
    begin
      @(posedge i_clock);
      {i_area_protect_bits, fwait} <= {4'h1, 4'h2};
      acc(`RDSG_MST_CPU, 1, 0, RA, RA, 0, 1, 32'h1234_5678);
      acc(`RDSG_MST_CPU, 0, 0, RA, RA, 0, 0, D4);
      acc(`RDSG_MST_CPU, 1, 0, 32'hbfc8_0014, RA, 0, 0, 32'hcafe_0001);
      acc(`RDSG_MST_CPU, 0, 0, 32'hbfc8_0014, RA, 0, 0, 32'hcafe_0001);
    end
  endtask
  task t_secure;
    begin
      @(posedge i_clock);
      {i_area_protect_bits, fwait} <= {4'hf, 4'h0};
      acc(`RDSG_MST_CPU, 0, 0, RA, OUT, 0, 1, 0);
      acc(`RDSG_MST_CPU, 0, 0, RA, RA, 0, 0, D4);
      chk({o_flash_secure, o_rom_secure}, 2'h2);
      cmd(`RDSG_CMD_WRITE, 0);
      cmd(`RDSG_CMD_ERASE, 0);
      cmd(`RDSG_CMD_OTHER, 0);
      cmd(`RDSG_CMD_PROT_CLR, 1);
      chk(o_chip_wipe, 1);
    end
  endtask
  task t_rom;
    begin
      pulse(3'h4, 1, RA);
      pulse(3'h2, 1, RA);
      chk({o_rom_secure, o_probe_secure}, 2'h3);
      acc(`RDSG_MST_CPU, 0, 0, RA, RA, 0, 0, D4);
      acc(`RDSG_MST_CPU, 0, 0, RA, OUT, 0, 1, 0);
      acc(`RDSG_MST_CPU, 1, 0, RA, OUT, 0, 1, 0);
      acc(`RDSG_MST_CPU, 0, 0, RA, RA, 1, 1, 0);
      acc(`RDSG_MST_CPU, 0, 0, OUT, OUT, 0, 0, 32'h5a5a_a5a0);
      acc(`RDSG_MST_CPU, 0, 1, RA, OUT, 0, 0, D4);
      for (m = 1; m < 6; m = m + 1)
        acc(m[2:0], 0, 0, RA, RA, 0, 1, 0);
      pulse(3'h4, 0, OUT);
      chk(o_rom_guard_reg_one, 1);
      pulse(3'h1, 0, OUT);
      chk({seen, o_bus_error}, 2'h1);
      pulse(3'h1, 0, RA);
      chk(seen, 1);
      cmd(`RDSG_CMD_PROT_CLR, 0);
      @(posedge i_clock);
      {i_trace_req, i_writer_mode} <= 2'h3;
      @(negedge i_clock);
      chk(o_trace_ok, 1);
      repeat (3) @(posedge i_clock);
      cmd(`RDSG_CMD_PROT_CLR, 1);
      cmd(`RDSG_CMD_WRITE, 0);
      @(posedge i_clock);
      i_area_protect_bits <= 4'h7;
      acc(`RDSG_MST_CPU, 0, 0, RA, OUT, 0, 0, D4);
      chk(o_rom_secure, 0);
    end
  endtask
  task summarize;
    begin
      $display("errors %0d, checks %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // Hang guard: the whole run needs under a hundred cycles.
  always @(posedge i_clock) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      error_cnt = error_cnt + 1;
      summarize;
    end
  end
  initial begin
    {i_clock, i_sys_rst, error_cnt, checked, cyc} = {2'h1, 96'h0};
    {i_writer_mode, i_req, i_write, i_fetch, i_pc_substituted, i_cmd_req} = 6'h0;
    {i_guard_one_wr, i_guard_two_wr, i_guard_wdata, i_dma_cfg_wr, i_trace_req} = 5'h0;
    {i_master, i_cmd, i_addr, i_pc, i_wdata, i_area_protect_bits, fwait} = 110'h0;
    repeat (3) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    #1;
    chk({o_rom_guard_reg_one, o_rom_guard_reg_two, o_flash_secure}, 3'h0);
    t_protect;
    t_secure;
    t_rom;
    summarize;
  end
endmodule
